// ==== verilog/ckos_pkg.sv ====
package ckos_pkg;
  // system clock
  localparam int unsigned CLK_HZ = 100_000_000;
  // output rates of the clock model, scaled down by 1000 so the 100 MHz logic can render them
  localparam int unsigned FREQ_HOST66_HZ = 66_667;
  localparam int unsigned FREQ_HOST100_HZ = 100_000;
  localparam int unsigned FREQ_HOST200_HZ = 200_000;
  localparam int unsigned FREQ_HOST133_HZ = 133_333;
  localparam int unsigned FREQ_FIX66_HZ = 66_667;
  localparam int unsigned FREQ_FIX48_HZ = 48_000;

  // register bus
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL0_OFS = 12'h000;
  localparam logic [11:0] REG_CTRL3_OFS = 12'h004;
  localparam logic [11:0] REG_STATUS_OFS = 12'h008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] CTRL0_RST = 8'h08;
  localparam logic [7:0] CTRL3_RST = 8'h00;
  localparam int CTRL0_VIDEO_BIT = 5;
  localparam int CTRL0_BUS_STOP_BIT = 3;
  localparam int CTRL3_FREE_LSB = 3;

  // select decode
  localparam logic [1:0] SEL_TRISTATE = 2'h0;
  localparam logic [1:0] SEL_TEST = 2'h1;
  localparam logic [1:0] SEL_HOST66 = 2'h0;
  localparam logic [1:0] SEL_HOST100 = 2'h1;
  localparam logic [1:0] SEL_HOST200 = 2'h2;

  // output vector layout
  localparam int VEC_W = 25;
  localparam int POS_HT = 0;
  localparam int POS_HC = 3;
  localparam int POS_BUS = 6;
  localparam int POS_COPY = 13;
  localparam int POS_FIX66 = 16;
  localparam int POS_VID = 17;
  localparam int POS_BUF66 = 18;
  localparam int POS_IO66 = 21;
  localparam int POS_REF = 22;
  localparam int POS_USB = 23;
  localparam int POS_DOT = 24;
  localparam logic [24:0] STOP_LVL = 25'h0000007;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_TRISTATE, MODE_TEST} ckos_mode_e;

  typedef struct packed {
    logic mid;
    logic top;
    logic [1:0] low;
    logic mult;
  } ckos_sel_s;

  typedef struct packed {
    ckos_mode_e mode;
    logic top;
    logic [1:0] low;
    logic video;
  } ckos_cfg_s;

  // phase increment for a 32-bit accumulator
  function automatic logic [31:0] ckos_nco_inc(input int unsigned f_hz);
    logic [63:0] p;
    p = 64'(f_hz) << 32;
    return 32'(p / 64'(CLK_HZ));
  endfunction

  function automatic logic [31:0] ckos_host_inc(input logic [1:0] low);
    case (low)
      SEL_HOST66: return ckos_nco_inc(FREQ_HOST66_HZ);
      SEL_HOST100: return ckos_nco_inc(FREQ_HOST100_HZ);
      SEL_HOST200: return ckos_nco_inc(FREQ_HOST200_HZ);
      default: return ckos_nco_inc(FREQ_HOST133_HZ);
    endcase
  endfunction

  function automatic ckos_mode_e ckos_decode(input ckos_sel_s s);
    if (s.mid && s.low == SEL_TRISTATE) return MODE_TRISTATE;
    if (s.mid && s.low == SEL_TEST) return MODE_TEST;
    return MODE_NORMAL;
  endfunction
endpackage

// ==== verilog/ckos_sync2.sv ====
`timescale 1ns/10ps
module ckos_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // raw and synchronised levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  // two flops, the first read only by the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule // ckos_sync2

// ==== verilog/ckos_nco.sv ====
`timescale 1ns/10ps
module ckos_nco (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic clr_in,
  input wire logic [31:0] inc_in,
  // square wave
  output logic level_out
);
  logic [31:0] acc_r;
  logic [31:0] inc_r;
  logic [32:0] sum;

  assign sum = {1'b0, acc_r} + {1'b0, inc_r};
  assign level_out = acc_r[31];

  // a new rate is taken at the wrap, where the level falls, or on a clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_r <= 32'h0;
      inc_r <= 32'h0;
    end else if (clr_in) begin
      acc_r <= 32'h0;
      inc_r <= inc_in;
    end else begin
      acc_r <= sum[31:0];
      if (sum[32]) begin
        inc_r <= inc_in;
      end
    end
  end
endmodule // ckos_nco

// ==== verilog/ckos_top.sv ====
`timescale 1ns/10ps
// Function
// - host pairs run at 66, 100, 200 or 133 MHz from the two low selects.
// - top select high buffers the external 66 input, bus clocks are it halved.
// - mid top select with 01 runs test mode, outputs other than the reference divided from the crystal input.
// - a mid top select during capture latches zero as the top state bit.
// - selects and multiplier are captured while power good is low, then held.
// - power down low stops all clocks; the register interface keeps working.
// - control byte 0 bit 5 picks 48 MHz, else 66 MHz, on the video clock.
// - control byte 3 bits 3 to 5 make each copy clock free running or stoppable.
// - each copy clock is the selected 66 MHz source divided by two.
// - the seven bus clocks stay in phase with the active 66 MHz source.
// - the reference output is a buffered copy of the crystal clock.
// - usb and dot clocks run at a fixed 48 MHz in normal modes.
// - the fixed 66 output runs at 66 MHz in normal modes.
// - bus stop low halts the seven bus clocks low, free copies keep running.
// - host stop low halts true outputs high and complement outputs low.
module ckos_top
  import ckos_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // register bus write
  input wire logic [11:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  // register bus read
  input wire logic [11:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // select and control pins
  input wire logic CRYSTAL_IN,
  input wire logic [1:0] FREQ_SEL_LOW_IN,
  input wire logic FREQ_SEL_TOP_IN,
  input wire logic FREQ_SEL_TOP_MID_IN,
  input wire logic POWER_GOOD_LATCH_N_IN,
  input wire logic POWER_DOWN_N_IN,
  input wire logic CURRENT_MULTIPLIER_SEL_IN,
  input wire logic BUS_CLOCK_STOP_N_IN,
  input wire logic HOST_CLOCK_STOP_N_IN,
  // two-way 66 MHz pin
  input wire logic SIXTYSIX_IO_IN,
  output logic SIXTYSIX_IO_OUT,
  output logic SIXTYSIX_IO_OE_N_OUT,
  // clock outputs
  output logic [2:0] HOST_CLOCK_TRUE_OUT,
  output logic [2:0] HOST_CLOCK_COMPLEMENT_OUT,
  output logic [6:0] BUS_CLOCK_OUT,
  output logic [2:0] HALF_RATE_COPY_CLOCK_OUT,
  output logic FIXED_SIXTYSIX_OUT,
  output logic SELECTABLE_VIDEO_CLOCK_OUT,
  output logic [2:0] BUFFERED_SIXTYSIX_OUT,
  output logic REFERENCE_OUT,
  output logic FIXED_USB_CLOCK_OUT,
  output logic FIXED_DOT_CLOCK_OUT,
  output logic CLOCK_OE_N_OUT
);
  logic [10:0] pin_raw;
  logic [10:0] pin_s;
  logic xtal_s, ext66_s, pg_n_s, pd_n_s, bus_stop_n_s, host_stop_n_s;
  ckos_sel_s sel_s;
  ckos_sel_s sel_lat_r;
  ckos_cfg_s cfg_r;
  ckos_cfg_s cfg_want;
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl3_r;
  logic [VEC_W-1:0] src_vec, want_vec, run_r, run_nxt, out_r;
  logic oe_n_r, io_oe_n_r;
  logic xtal_d_r, s66_d_r, bus_div_r;
  logic [2:0] test_cnt_r;
  logic nco_host, nco66, nco48, div_clr, cfg_pending, run_ok, bus_stop_eff;
  logic s66, s66_rise, xtal_rise;
  logic awready_r, wready_r, aw_have_r, w_have_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, rd_data;
  logic [3:0] wstrb_r;
  logic do_write, aw_hs, w_hs, ar_hs, rd_hit, wr_hit;

  // pins pass two flops before use
  assign pin_raw = {CRYSTAL_IN, SIXTYSIX_IO_IN, FREQ_SEL_TOP_MID_IN, FREQ_SEL_TOP_IN, FREQ_SEL_LOW_IN,
                    CURRENT_MULTIPLIER_SEL_IN, POWER_GOOD_LATCH_N_IN, POWER_DOWN_N_IN,
                    BUS_CLOCK_STOP_N_IN, HOST_CLOCK_STOP_N_IN};

  ckos_sync2 #(.W(11)) u_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .d_in(pin_raw),
    .q_out(pin_s)
  );

  // named views of synchronised pins
  assign xtal_s = pin_s[10];
  assign ext66_s = pin_s[9];
  assign sel_s = ckos_sel_s'({pin_s[8:5], pin_s[4]});
  assign pg_n_s = pin_s[3];
  assign pd_n_s = pin_s[2];
  assign bus_stop_n_s = pin_s[1];
  assign host_stop_n_s = pin_s[0];

  // select capture while power good is low
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_lat_r <= '0;
    end else if (!pg_n_s) begin
      sel_lat_r <= '{mid: sel_s.mid, top: sel_s.top & ~sel_s.mid, low: sel_s.low, mult: sel_s.mult};
    end
  end

  // wanted configuration and the gate that applies it
  assign cfg_want = '{mode: ckos_decode(sel_lat_r), top: sel_lat_r.top, low: sel_lat_r.low,
                      video: ctrl0_r[CTRL0_VIDEO_BIT]};
  assign cfg_pending = (cfg_want != cfg_r);
  assign run_ok = pd_n_s & ~cfg_pending & (cfg_r.mode != MODE_TRISTATE);
  assign bus_stop_eff = bus_stop_n_s & ctrl0_r[CTRL0_BUS_STOP_BIT];
  assign div_clr = ~pd_n_s & (run_r == '0);

  // a new setting waits until every output has parked
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cfg_r <= '{mode: MODE_NORMAL, top: 1'b0, low: 2'h0, video: 1'b0};
    end else if (cfg_pending && run_r == '0) begin
      cfg_r <= cfg_want;
    end
  end

  // rate generators
  ckos_nco u_nco_host (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .clr_in(div_clr),
    .inc_in(ckos_host_inc(cfg_r.low)),
    .level_out(nco_host)
  );

  ckos_nco u_nco66 (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .clr_in(div_clr),
    .inc_in(ckos_nco_inc(FREQ_FIX66_HZ)),
    .level_out(nco66)
  );

  ckos_nco u_nco48 (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .clr_in(div_clr),
    .inc_in(ckos_nco_inc(FREQ_FIX48_HZ)),
    .level_out(nco48)
  );

  // active 66 source and edges
  assign s66 = cfg_r.top ? ext66_s : nco66;
  assign s66_rise = s66 & ~s66_d_r;
  assign xtal_rise = xtal_s & ~xtal_d_r;

  // half-rate divider on the 66 source and test divider on the crystal
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s66_d_r <= 1'b0;
      xtal_d_r <= 1'b0;
      bus_div_r <= 1'b0;
      test_cnt_r <= 3'h0;
    end else begin
      s66_d_r <= s66;
      xtal_d_r <= xtal_s;
      if (div_clr) begin
        bus_div_r <= 1'b0;
        test_cnt_r <= 3'h0;
      end else begin
        bus_div_r <= bus_div_r ^ s66_rise;
        test_cnt_r <= test_cnt_r + {2'h0, xtal_rise};
      end
    end
  end

  // clock sources per output, normal or test
  always_comb begin
    if (cfg_r.mode == MODE_TEST) begin
      src_vec = {test_cnt_r[0], test_cnt_r[0], xtal_s, test_cnt_r[1], {3{test_cnt_r[1]}}, test_cnt_r[1],
                 test_cnt_r[1], {3{test_cnt_r[2]}}, {7{test_cnt_r[2]}}, {3{~test_cnt_r[0]}},
                 {3{test_cnt_r[0]}}};
    end else begin
      src_vec = {nco48, nco48, xtal_s, nco66, {3{s66}}, cfg_r.video ? nco48 : nco66, nco66,
                 {3{bus_div_r}}, {7{bus_div_r}}, {3{~nco_host}}, {3{nco_host}}};
    end
  end

  // which outputs may run
  assign want_vec = {{9{run_ok}}, {3{run_ok}} & (ctrl3_r[CTRL3_FREE_LSB +: 3] | {3{bus_stop_eff}}),
                     {7{run_ok & bus_stop_eff}}, {6{run_ok & host_stop_n_s}}};

  // run flags change only while the output sits at its parked level
  assign run_nxt = (want_vec & ~(src_vec ^ STOP_LVL)) | (run_r & (src_vec ^ STOP_LVL));

  // output flops
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      run_r <= '0;
      out_r <= STOP_LVL;
      oe_n_r <= 1'b0;
      io_oe_n_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      out_r <= (run_nxt & src_vec) | (~run_nxt & STOP_LVL);
      oe_n_r <= (cfg_r.mode == MODE_TRISTATE);
      io_oe_n_r <= (cfg_r.mode == MODE_TRISTATE) | (cfg_r.mode == MODE_NORMAL && cfg_r.top);
    end
  end

  // clock pins
  assign HOST_CLOCK_TRUE_OUT = out_r[POS_HT +: 3];
  assign HOST_CLOCK_COMPLEMENT_OUT = out_r[POS_HC +: 3];
  assign BUS_CLOCK_OUT = out_r[POS_BUS +: 7];
  assign HALF_RATE_COPY_CLOCK_OUT = out_r[POS_COPY +: 3];
  assign FIXED_SIXTYSIX_OUT = out_r[POS_FIX66];
  assign SELECTABLE_VIDEO_CLOCK_OUT = out_r[POS_VID];
  assign BUFFERED_SIXTYSIX_OUT = out_r[POS_BUF66 +: 3];
  assign SIXTYSIX_IO_OUT = out_r[POS_IO66];
  assign REFERENCE_OUT = out_r[POS_REF];
  assign FIXED_USB_CLOCK_OUT = out_r[POS_USB];
  assign FIXED_DOT_CLOCK_OUT = out_r[POS_DOT];
  assign CLOCK_OE_N_OUT = oe_n_r;
  assign SIXTYSIX_IO_OE_N_OUT = io_oe_n_r;

  // bus handshakes
  assign aw_hs = S_AXI_AWVALID_IN & awready_r;
  assign w_hs = S_AXI_WVALID_IN & wready_r;
  assign ar_hs = S_AXI_ARVALID_IN & arready_r;
  assign do_write = aw_have_r & w_have_r & ~bvalid_r;
  assign wr_hit = (awaddr_r == REG_CTRL0_OFS) | (awaddr_r == REG_CTRL3_OFS);

  // write channel: address and data in either order, then one response
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_r <= S_AXI_AWADDR_IN;
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (w_hs) begin
        wdata_r <= S_AXI_WDATA_IN;
        wstrb_r <= S_AXI_WSTRB_IN;
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY_IN) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // control registers, byte lane 0 only
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl0_r <= CTRL0_RST;
      ctrl3_r <= CTRL3_RST;
    end else if (do_write && wstrb_r[0]) begin
      if (awaddr_r == REG_CTRL0_OFS) begin
        ctrl0_r <= {wdata_r[7:5], 1'b0, wdata_r[3], 3'h0};
      end
      if (awaddr_r == REG_CTRL3_OFS) begin
        ctrl3_r <= {2'h0, wdata_r[5:3], 3'h0};
      end
    end
  end

  // read decode
  assign rd_hit = (S_AXI_ARADDR_IN == REG_CTRL0_OFS) | (S_AXI_ARADDR_IN == REG_CTRL3_OFS) |
                  (S_AXI_ARADDR_IN == REG_STATUS_OFS);
  assign rd_data = (S_AXI_ARADDR_IN == REG_CTRL0_OFS) ?
                     {24'h0, ctrl0_r[7:5], host_stop_n_s, bus_stop_eff, sel_lat_r.top, sel_lat_r.low} :
                   (S_AXI_ARADDR_IN == REG_CTRL3_OFS) ? {24'h0, ctrl3_r} :
                   (S_AXI_ARADDR_IN == REG_STATUS_OFS) ?
                     {26'h0, sel_lat_r.mult, sel_lat_r.mid, cfg_r.mode, cfg_pending, (run_r != '0)} : 32'h0;

  // read channel
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY_IN) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // bus pins
  assign S_AXI_AWREADY_OUT = awready_r;
  assign S_AXI_WREADY_OUT = wready_r;
  assign S_AXI_BVALID_OUT = bvalid_r;
  assign S_AXI_BRESP_OUT = bresp_r;
  assign S_AXI_ARREADY_OUT = arready_r;
  assign S_AXI_RVALID_OUT = rvalid_r;
  assign S_AXI_RDATA_OUT = rdata_r;
  assign S_AXI_RRESP_OUT = rresp_r;

  // checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_pd_parked;
    (!pd_n_s && run_r == '0) ##1 !pd_n_s;
  endsequence

  a_tristate_oe: assert property ((cfg_r.mode == MODE_TRISTATE) |=> (oe_n_r && io_oe_n_r))
    else $error("tristate mode left outputs enabled");
  a_sel_held: assert property ($past(pg_n_s) |-> $stable(sel_lat_r))
    else $error("latched selects changed while power good high");
  a_mid_top_zero: assert property ((!pg_n_s && sel_s.mid) |=> (sel_lat_r.mid && !sel_lat_r.top))
    else $error("mid level top select not latched as zero");
  a_pd_parked: assert property (s_pd_parked |-> (out_r == STOP_LVL))
    else $error("outputs not parked in power down");
  a_bus_stop_low: assert property (!run_r[POS_BUS] |-> !out_r[POS_BUS])
    else $error("stopped bus clock not low");
  a_host_stop_lvl: assert property ((!run_r[POS_HT] && !run_r[POS_HC]) |-> (out_r[POS_HT] && !out_r[POS_HC]))
    else $error("stopped host pair at wrong levels");
  a_gate_boundary: assert property (((run_r ^ $past(run_r)) & ($past(src_vec) ^ STOP_LVL)) == '0)
    else $error("gate changed away from parked level");
  a_cfg_idle: assert property ((cfg_r != $past(cfg_r)) |-> ($past(run_r) == '0))
    else $error("configuration applied while outputs ran");
  a_video_48: assert property ((cfg_r.mode == MODE_NORMAL && cfg_r.video && run_nxt[POS_VID]) |=>
                               (out_r[POS_VID] == $past(nco48)))
    else $error("video clock not on 48 MHz source");
  a_half_rate: assert property ((s66_rise && !div_clr) |=> (bus_div_r != $past(bus_div_r)))
    else $error("half-rate divider missed a source edge");
endmodule // ckos_top

// ==== tb/ckos_ext66_src.sv ====
`timescale 1ns/10ps
module ckos_ext66_src #(
  parameter int HALF = 30
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // enable and external clock
  input wire logic en_in,
  output logic clk66_out
);
  int cnt_r;
  // square wave while enabled, held low when not
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in || !en_in) begin
      cnt_r <= 0;
      clk66_out <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
      if (cnt_r == HALF - 1) clk66_out <= ~clk66_out;
    end
  end
endmodule // ckos_ext66_src

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import ckos_pkg::*;
;
  localparam int XH = 7;
  localparam int XP = 2 * XH;
  localparam int EH = 30;
  // inputs, named as the ports
  logic SYS_CLK_IN = 0, RST_IN = 1, CRYSTAL_IN = 0, FREQ_SEL_TOP_IN = 0, FREQ_SEL_TOP_MID_IN = 0;
  logic S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0, S_AXI_ARVALID_IN = 0;
  logic S_AXI_RREADY_IN = 0, POWER_GOOD_LATCH_N_IN = 1, POWER_DOWN_N_IN = 1, CURRENT_MULTIPLIER_SEL_IN = 0;
  logic BUS_CLOCK_STOP_N_IN = 1, HOST_CLOCK_STOP_N_IN = 1;
  logic [11:0] S_AXI_AWADDR_IN = 0, S_AXI_ARADDR_IN = 0;
  logic [31:0] S_AXI_WDATA_IN = 0;
  logic [3:0] S_AXI_WSTRB_IN = 4'hf;
  logic [1:0] FREQ_SEL_LOW_IN = 0;
  wire SIXTYSIX_IO_IN;
  // outputs
  logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
  logic SIXTYSIX_IO_OUT, SIXTYSIX_IO_OE_N_OUT, FIXED_SIXTYSIX_OUT, SELECTABLE_VIDEO_CLOCK_OUT;
  logic REFERENCE_OUT, FIXED_USB_CLOCK_OUT, FIXED_DOT_CLOCK_OUT, CLOCK_OE_N_OUT;
  logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
  logic [31:0] S_AXI_RDATA_OUT, d, x;
  logic [2:0] HOST_CLOCK_TRUE_OUT, HOST_CLOCK_COMPLEMENT_OUT, HALF_RATE_COPY_CLOCK_OUT, BUFFERED_SIXTYSIX_OUT;
  logic [6:0] BUS_CLOCK_OUT;
  logic [1:0] r;
  logic [24:0] mv;
  logic ext_clk, ext_en = 0;
  logic [31:0] seed = 32'h00004ae5;
  int mismatches = 0, cmp_count = 0, xc = 0;
  int m_mode = 0, m_top = 0, m_low = 0, m_vid = 0;
  // all clock outputs in the package's vector layout
  wire [24:0] vec = {FIXED_DOT_CLOCK_OUT, FIXED_USB_CLOCK_OUT, REFERENCE_OUT, SIXTYSIX_IO_OUT,
    BUFFERED_SIXTYSIX_OUT, SELECTABLE_VIDEO_CLOCK_OUT, FIXED_SIXTYSIX_OUT, HALF_RATE_COPY_CLOCK_OUT,
    BUS_CLOCK_OUT, HOST_CLOCK_COMPLEMENT_OUT, HOST_CLOCK_TRUE_OUT};
  // two-way pin level from the design's enable
  assign SIXTYSIX_IO_IN = SIXTYSIX_IO_OE_N_OUT ? ext_clk : SIXTYSIX_IO_OUT;

  ckos_top dut (.*);
  ckos_ext66_src #(.HALF(EH)) ext (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .en_in(ext_en), .clk66_out(ext_clk));

  initial begin
    forever #5 SYS_CLK_IN = ~SYS_CLK_IN;
  end
  // crystal stand-in, period XP cycles
  always @(posedge SYS_CLK_IN) begin
    xc <= (xc == XH - 1) ? 0 : xc + 1;
    if (xc == XH - 1) CRYSTAL_IN <= ~CRYSTAL_IN;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected period in cycles of the output at vector position p
  function automatic int eper(input int p);
    int f66;
    f66 = CLK_HZ / FREQ_FIX66_HZ;
    if (m_mode == 2) return (p < 6 || p > 22) ? 2 * XP : (p < 16) ? 8 * XP : (p == 22) ? XP : 4 * XP;
    if (p < 6) return CLK_HZ / (m_low == 0 ? FREQ_HOST66_HZ : m_low == 1 ? FREQ_HOST100_HZ :
      m_low == 2 ? FREQ_HOST200_HZ : FREQ_HOST133_HZ);
    if (p < 16) return m_top ? 4 * EH : 2 * f66;
    if (p == 17 && m_vid) return CLK_HZ / FREQ_FIX48_HZ;
    if (p == 18 || p == 21) return m_top ? 2 * EH : f66;
    if (p == 22) return XP;
    if (p > 22) return CLK_HZ / FREQ_FIX48_HZ;
    return f66;
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tmo();
    mismatches++;
    $display("CHECK FAILED wait expected done seen timeout");
    stop_test();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkp(input string nm, input int e, input int g);
    cmp_count++;
    if (g > e + 3 || g < e - 3) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  // register bus write and read, each channel released when taken
  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit ad, wd;
    int n;
    @(posedge SYS_CLK_IN);
    S_AXI_AWADDR_IN <= a;
    S_AXI_WDATA_IN <= v;
    S_AXI_AWVALID_IN <= 1;
    S_AXI_WVALID_IN <= 1;
    S_AXI_BREADY_IN <= 1;
    ad = 0;
    wd = 0;
    for (n = 0; n < 50; n++) begin
      @(posedge SYS_CLK_IN);
      if (ad && wd && S_AXI_BVALID_OUT) break;
      if (!ad && S_AXI_AWREADY_OUT) begin
        ad = 1;
        S_AXI_AWVALID_IN <= 0;
      end
      if (!wd && S_AXI_WREADY_OUT) begin
        wd = 1;
        S_AXI_WVALID_IN <= 0;
      end
    end
    if (n >= 50) tmo();
    rs = S_AXI_BRESP_OUT;
    S_AXI_BREADY_IN <= 0;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge SYS_CLK_IN);
    S_AXI_ARADDR_IN <= a;
    S_AXI_ARVALID_IN <= 1;
    S_AXI_RREADY_IN <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge SYS_CLK_IN);
      if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 0;
      if (S_AXI_RVALID_OUT) break;
    end
    if (n >= 50) tmo();
    v = S_AXI_RDATA_OUT;
    rs = S_AXI_RRESP_OUT;
    S_AXI_RREADY_IN <= 0;
  endtask

  task automatic wt(input int p, input logic v, inout int n);
    while (vec[p] !== v && n < 20000) begin
      @(posedge SYS_CLK_IN);
      n++;
    end
    if (n >= 20000) tmo();
  endtask

  // one full period of an output, rise to rise
  task automatic meas(input int p);
    int n, n0;
    n = 0;
    wt(p, 0, n);
    wt(p, 1, n);
    n0 = n;
    wt(p, 0, n);
    wt(p, 1, n);
    chkp($sformatf("period of output %0d", p), eper(p), n - n0);
  endtask

  task automatic watch(input int c, output logic [24:0] m);
    logic [24:0] pv;
    m = '0;
    pv = vec;
    repeat (c) begin
      @(posedge SYS_CLK_IN);
      m = m | (vec ^ pv);
      pv = vec;
    end
  endtask

  task automatic settle();
    logic [31:0] s;
    logic [1:0] q;
    repeat (8) @(posedge SYS_CLK_IN);
    for (int i = 0; i < 3000; i++) begin
      axr(REG_STATUS_OFS, s, q);
      if (s[1] === 1'b0) return;
    end
    tmo();
  endtask

  // capture selects, then scramble the pins while they must be held
  task automatic cap(input logic mid, input logic top, input logic [1:0] low, input logic mul);
    logic [31:0] g;
    @(posedge SYS_CLK_IN);
    FREQ_SEL_TOP_MID_IN <= mid;
    FREQ_SEL_TOP_IN <= top;
    FREQ_SEL_LOW_IN <= low;
    CURRENT_MULTIPLIER_SEL_IN <= mul;
    POWER_GOOD_LATCH_N_IN <= 0;
    repeat (6) @(posedge SYS_CLK_IN);
    POWER_GOOD_LATCH_N_IN <= 1;
    repeat (4) @(posedge SYS_CLK_IN);
    g = rnd();
    FREQ_SEL_TOP_MID_IN <= g[0];
    FREQ_SEL_TOP_IN <= g[1];
    FREQ_SEL_LOW_IN <= g[3:2];
    CURRENT_MULTIPLIER_SEL_IN <= g[4];
    m_top = top & ~mid;
    m_low = low;
    m_mode = !mid ? 0 : (low == 2'h0) ? 1 : 2;
    settle();
  endtask

  initial begin
    repeat (2) @(posedge SYS_CLK_IN);
    RST_IN <= 0;
    // let the pin synchronisers flush before the first read of pin-derived bits
    repeat (2) @(posedge SYS_CLK_IN);
    axr(REG_CTRL0_OFS, d, r);
    chk("ctrl0 reset", 32'h18, d);
    // a write with byte lane 0 masked must leave control3 at its reset value
    S_AXI_WSTRB_IN <= 4'h0;
    axw(REG_CTRL3_OFS, 32'h38, r);
    S_AXI_WSTRB_IN <= 4'hf;
    axr(REG_CTRL3_OFS, d, r);
    chk("ctrl3 reset", 32'h0, d);
    axr(12'h00c, d, r);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {d[29:0], r});
    axw(12'h010, 32'hff, r);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    tend("registers");
    cap(0, 0, 0, 1);
    axr(REG_STATUS_OFS, d, r);
    chk("multiplier", 32'h1, {31'h0, d[5]});
    for (int l = 0; l < 4; l++) begin
      cap(0, 0, l[1:0], 0);
      meas(POS_HT);
    end
    chk("io drive", 32'h0, {31'h0, SIXTYSIX_IO_OE_N_OUT});
    meas(POS_BUS);
    meas(POS_COPY);
    meas(POS_FIX66);
    meas(POS_VID);
    meas(POS_REF);
    meas(POS_USB);
    x = rnd();
    x[3] = 1;
    x[5] = 1;
    axw(REG_CTRL0_OFS, x, r);
    m_vid = 1;
    settle();
    axr(REG_CTRL0_OFS, d, r);
    chk("ctrl0", {24'h0, x[7:5], 5'h1b}, d);
    meas(POS_VID);
    axw(REG_CTRL0_OFS, 32'h08, r);
    m_vid = 0;
    settle();
    tend("internal source");
    ext_en <= 1;
    cap(0, 1, 3, 0);
    chk("io release", 32'h1, {31'h0, SIXTYSIX_IO_OE_N_OUT});
    axr(REG_CTRL0_OFS, d, r);
    chk("held selects", 32'h7, {29'h0, d[2:0]});
    meas(POS_BUF66);
    meas(POS_BUS);
    meas(POS_COPY);
    tend("external source");
    HOST_CLOCK_STOP_N_IN <= 0;
    repeat (1600) @(posedge SYS_CLK_IN);
    watch(1600, mv);
    chk("host parked", 32'h7, {20'h0, mv[5:0], vec[5:0]});
    chk("bus running", 32'h7f, {25'h0, mv[12:6]});
    axr(REG_CTRL0_OFS, d, r);
    chk("host stop bit", 32'h0, {31'h0, d[4]});
    HOST_CLOCK_STOP_N_IN <= 1;
    axw(REG_CTRL3_OFS, 32'h28, r);
    BUS_CLOCK_STOP_N_IN <= 0;
    repeat (300) @(posedge SYS_CLK_IN);
    watch(300, mv);
    chk("bus parked", 32'h5, {15'h0, mv[12:6], vec[12:6], mv[15:13]});
    BUS_CLOCK_STOP_N_IN <= 1;
    axw(REG_CTRL0_OFS, 32'h0, r);
    repeat (300) @(posedge SYS_CLK_IN);
    watch(300, mv);
    axr(REG_CTRL0_OFS, d, r);
    chk("bus stop bit", 32'h5, {21'h0, mv[12:6], d[3], mv[15:13]});
    axw(REG_CTRL0_OFS, 32'h08, r);
    repeat (300) @(posedge SYS_CLK_IN);
    watch(300, mv);
    chk("bus restart", 32'h7f, {25'h0, mv[12:6]});
    tend("stops");
    POWER_DOWN_N_IN <= 0;
    repeat (2000) @(posedge SYS_CLK_IN);
    watch(1500, mv);
    chk("power down", 32'h0, {7'h0, mv});
    axr(REG_CTRL3_OFS, d, r);
    chk("regs alive", 32'h28, d);
    POWER_DOWN_N_IN <= 1;
    repeat (2000) @(posedge SYS_CLK_IN);
    watch(1600, mv);
    chk("wake", 32'h3f, {26'h0, mv[5:0]});
    tend("power down");
    cap(1, 1, 1, 0);
    axr(REG_CTRL0_OFS, d, r);
    chk("mid latch", 32'h1, {29'h0, d[2:0]});
    axr(REG_STATUS_OFS, d, r);
    chk("test mode", 32'h6, {29'h0, d[4:2]});
    meas(POS_HT);
    meas(POS_BUF66);
    meas(POS_BUS);
    meas(POS_COPY);
    meas(POS_REF);
    meas(POS_USB);
    cap(1, 0, 0, 0);
    chk("tristate", 32'h1, {31'h0, CLOCK_OE_N_OUT});
    cap(0, 0, 0, 0);
    chk("drive again", 32'h0, {31'h0, CLOCK_OE_N_OUT});
    tend("test and tristate");
    stop_test();
  end
endmodule // tb_top
